// ---- plsram_pkg.sv ----
package plsram_pkg;

    // Default organisation: 128K words of 36 bits
    localparam int ADDR_W_DFLT = 17;
    localparam int DATA_W_DFLT = 36;

    // Byte lanes and write masks
    localparam int LANE_CNT = 4;

    // Burst counter and its seed
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_SEED_RST = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;

    // Late-write address buffer depth
    localparam int WBUF_DEPTH = 2;

    // Static pin encodings
    localparam logic BURST_INTERLEAVED = 1'h1;
    localparam logic RW_READ = 1'h1;

    // Reset values of the pipeline flops
    localparam logic SNZ_RST = 1'h0;
    localparam logic RD_VALID_RST = 1'h0;

    typedef logic [BURST_W-1:0] plsram_burst_t;
    typedef logic [LANE_CNT-1:0] plsram_mask_t;

    // Operation fixed when an address is loaded
    typedef enum logic [1:0] {
        OP_DESEL = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10
    } plsram_op_t;

endpackage

// ---- plsram_wbuf_if.sv ----
`timescale 1ns/100ps

interface plsram_wbuf_if #(
    parameter int ADDR_W = plsram_pkg::ADDR_W_DFLT
);
    // Fill side: write address phase
    logic push_valid;
    logic push_ready;
    logic [ADDR_W-1:0] push_addr;
    plsram_pkg::plsram_mask_t push_mask;
    // Drain side: write data phase
    logic pop_valid;
    logic pop_ready;
    logic [ADDR_W-1:0] pop_addr;
    plsram_pkg::plsram_mask_t pop_mask;

    modport core (
        output push_valid,
        input push_ready,
        output push_addr,
        output push_mask,
        input pop_valid,
        output pop_ready,
        input pop_addr,
        input pop_mask
    );

    modport store (
        input push_valid,
        output push_ready,
        input push_addr,
        input push_mask,
        output pop_valid,
        input pop_ready,
        output pop_addr,
        output pop_mask
    );
endinterface

// ---- plsram_wbuf.sv ----
`timescale 1ns/100ps

module plsram_wbuf #(
    parameter int ADDR_W = plsram_pkg::ADDR_W_DFLT,
    parameter int DEPTH = plsram_pkg::WBUF_DEPTH
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    plsram_wbuf_if.store wb_io
);
    import plsram_pkg::*;

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [ADDR_W-1:0] addr_r [DEPTH];
    plsram_mask_t mask_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic push;
    logic pop;

    // Honest full and empty straight from the fill count
    assign wb_io.push_ready = (count_r != CNT_FULL);
    assign wb_io.pop_valid = (count_r != '0);
    assign wb_io.pop_addr = addr_r[rd_ptr_r];
    assign wb_io.pop_mask = mask_r[rd_ptr_r];
    assign push = wb_io.push_valid & wb_io.push_ready;
    assign pop = wb_io.pop_valid & wb_io.pop_ready;

    // Entry storage needs no reset; count guards it
    always_ff @(posedge mclk_in) begin
        if (push) begin
            addr_r[wr_ptr_r] <= wb_io.push_addr;
            mask_r[wr_ptr_r] <= wb_io.push_mask;
        end
    end

    // Pointers wrap explicitly so odd depths also work
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PTR_W'(1);
            end
        end
    end

    // Occupancy; simultaneous push and pop leave it unchanged
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + CNT_W'(1);
        end else if (pop && !push) begin
            count_r <= count_r - CNT_W'(1);
        end
    end
endmodule

// ---- plsram_port.sv ----
`timescale 1ns/100ps

module plsram_port #(
    parameter int ADDR_W = plsram_pkg::ADDR_W_DFLT,
    parameter int DATA_W = plsram_pkg::DATA_W_DFLT
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clock_enable_n_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic advance_or_load_n_in,
    input wire logic read_not_write_in,
    input wire logic chip_enable_n_in,
    input wire logic expansion_select_high_in,
    input wire logic expansion_select_low_n_in,
    input wire logic lane0_write_mask_n_in,
    input wire logic lane1_write_mask_n_in,
    input wire logic lane2_write_mask_n_in,
    input wire logic lane3_write_mask_n_in,
    input wire logic burst_order_in,
    input wire logic output_enable_n_in,
    input wire logic snooze_request_in,
    input wire logic [DATA_W-1:0] lane_data_in,
    output logic [DATA_W-1:0] lane_data_out,
    output logic lane_data_oe_out,
    output logic standby_out
);
    import plsram_pkg::*;

    localparam int LANES = (DATA_W == 18) ? 2 : LANE_CNT;
    localparam int LANE_W = DATA_W / LANES;
    localparam int DEPTH = 1 << ADDR_W;

    logic snz_meta_r;
    logic snz_sync_r;
    logic step;
    logic go;
    logic load_now;
    logic sel_now;
    plsram_op_t op_now;
    plsram_op_t op_r;
    plsram_burst_t cnt_r;
    plsram_burst_t cnt_nxt;
    plsram_burst_t base_lo_r;
    plsram_burst_t burst_lo;
    logic [ADDR_W-BURST_W-1:0] base_hi_r;
    logic [ADDR_W-1:0] acc_addr;
    plsram_mask_t wr_mask;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] rd_data_r;
    logic rd_valid_r;

    plsram_wbuf_if #(.ADDR_W(ADDR_W)) wb ();

    // Late-write address buffer; two entries absorb a drain stall
    plsram_wbuf #(
        .ADDR_W(ADDR_W),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wb_io(wb.store)
    );

    // snooze pin is asynchronous, so two flops first
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            snz_meta_r <= SNZ_RST;
            snz_sync_r <= SNZ_RST;
        end else begin
            snz_meta_r <= snooze_request_in;
            snz_sync_r <= snz_meta_r;
        end
    end

    // clock enable high stretches the previous cycle
    // snooze freezes the core and ignores every pin
    assign step = ~clock_enable_n_in & ~snz_sync_r;

    // suspend gate; also stalls if the write buffer is full
    assign go = step & wb.push_ready;

    // Masks arrive with the address; low means write that lane
    assign wr_mask = ~{lane3_write_mask_n_in, lane2_write_mask_n_in,
                       lane1_write_mask_n_in, lane0_write_mask_n_in};

    // Load decode, chip select and operation for this edge
    always_comb begin
        // load strobe low starts every operation
        load_now = ~advance_or_load_n_in;
        // all three enables must be true to select
        sel_now = ~chip_enable_n_in & expansion_select_high_in & ~expansion_select_low_n_in;
        // type fixed only on load; enables seen only then
        // on advance the read/write pin is ignored
        if (load_now) begin
            if (!sel_now) begin
                op_now = OP_DESEL;
            end else if (read_not_write_in == RW_READ) begin
                op_now = OP_READ;
            end else begin
                op_now = OP_WRITE;
            end
        end else begin
            op_now = op_r;
        end
    end

    // Burst offset and address for the access at this edge
    always_comb begin
        // two-bit counter wraps naturally after four
        // advance steps the counter, load restarts it
        if (load_now) begin
            cnt_nxt = BURST_SEED_RST;
        end else begin
            cnt_nxt = cnt_r + BURST_STEP;
        end
        // static order pin chooses the sequence
        // interleave by XOR, linear by modulo-four add
        if (burst_order_in == BURST_INTERLEAVED) begin
            burst_lo = base_lo_r ^ cnt_nxt;
        end else begin
            burst_lo = base_lo_r + cnt_nxt;
        end
        // a fresh load uses the pin address directly
        if (load_now) begin
            acc_addr = address_in;
        end else begin
            acc_addr = {base_hi_r, burst_lo};
        end
    end

    // base address captured on the load edge
    // low two bits seed the burst sequence
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            base_hi_r <= '0;
            base_lo_r <= BURST_SEED_RST;
        end else if (go && load_now) begin
            base_hi_r <= address_in[ADDR_W-1:BURST_W];
            base_lo_r <= address_in[BURST_W-1:0];
        end
    end

    // Burst counter advances or restarts on every accepted edge
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= BURST_SEED_RST;
        end else if (go) begin
            cnt_r <= cnt_nxt;
        end
    end

    // operation held across the burst until the next load
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_r <= OP_DESEL;
        end else if (go && load_now) begin
            op_r <= op_now;
        end
    end

    // write address and masks queued for the data edge
    // masks are taken with the address, not the data
    assign wb.push_valid = step & (op_now == OP_WRITE);
    assign wb.push_addr = acc_addr;
    assign wb.push_mask = wr_mask;
    // data phase drains the entry on the next edge
    assign wb.pop_ready = step;

    // Per-lane array, write commit and read with forwarding
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [LANE_W-1:0] lane_mem_r [DEPTH];
        logic commit;
        logic fwd;

        // each lane's own mask gates only that lane
        // any mix of one to four lanes (one or two at 18 bits) may be written
        assign commit = wb.pop_valid & wb.pop_ready & wb.pop_mask[i];

        // Array is never reset, so snooze and reset keep contents
        always_ff @(posedge mclk_in) begin
            if (commit) begin
                lane_mem_r[wb.pop_addr] <= lane_data_in[i*LANE_W +: LANE_W];
            end
        end

        // read right after write sees the committing data
        assign fwd = commit & (wb.pop_addr == acc_addr);
        assign rd_word[i*LANE_W +: LANE_W] = fwd ? lane_data_in[i*LANE_W +: LANE_W] :
                                              lane_mem_r[acc_addr];
    end

    // Read word lands in the output flop at the access edge
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_r <= '0;
        end else if (go && (op_now == OP_READ)) begin
            rd_data_r <= rd_word;
        end
    end

    // drive window ends at the next non-read edge, no gap
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_valid_r <= RD_VALID_RST;
        end else if (go) begin
            rd_valid_r <= (op_now == OP_READ);
        end
    end

    assign lane_data_out = rd_data_r;
    // asynchronous enable; snooze also releases the bus
    assign lane_data_oe_out = rd_valid_r & ~output_enable_n_in & ~snz_sync_r;
    // standby status follows the synchronised request
    assign standby_out = snz_sync_r;
endmodule

// ---- plsram_sva.sv ----
`timescale 1ns/100ps

module plsram_sva #(
    parameter int DATA_W = 36
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clock_enable_n_in,
    input wire logic advance_or_load_n_in,
    input wire logic read_not_write_in,
    input wire logic chip_enable_n_in,
    input wire logic expansion_select_high_in,
    input wire logic expansion_select_low_n_in,
    input wire logic output_enable_n_in,
    input wire logic snooze_request_in,
    input wire logic [DATA_W-1:0] lane_data_out,
    input wire logic lane_data_oe_out,
    input wire logic standby_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    logic live;
    logic picked;
    logic load;
    // Accepted edge, full selection and a load edge
    assign live = !clock_enable_n_in && !standby_out;
    assign picked = !chip_enable_n_in && expansion_select_high_in && !expansion_select_low_n_in;
    assign load = live && !advance_or_load_n_in;
    // Drive follows the operation fixed at load; the async enable and snooze win
    a_deselect_no_drive: assert property (load && !picked |=> !lane_data_oe_out)
        else $error("drive after deselect load");
    a_write_no_drive: assert property (load && picked && !read_not_write_in |=> !lane_data_oe_out)
        else $error("drive after write load");
    a_read_drives: assert property (load && picked && read_not_write_in |=> lane_data_oe_out || output_enable_n_in || standby_out)
        else $error("no drive after read load");
    a_advance_keeps_read: assert property (live && advance_or_load_n_in && lane_data_oe_out |=> lane_data_oe_out || output_enable_n_in || standby_out)
        else $error("read burst lost on advance");
    a_oe_pin_off: assert property (output_enable_n_in |-> !lane_data_oe_out)
        else $error("drive with enable pin high");
    a_standby_quiet: assert property (standby_out |-> !lane_data_oe_out ##1 $stable(lane_data_out))
        else $error("activity in standby");
    a_standby_two_edges: assert property ($past(rst_n_in, 2) |-> standby_out == $past(snooze_request_in, 2))
        else $error("standby latency wrong");
    a_suspend_holds: assert property (clock_enable_n_in |=> $stable(lane_data_out))
        else $error("data moved while suspended");
    // Main scenarios
    c_read_write: cover property (load && picked && read_not_write_in ##1 load && picked && !read_not_write_in);
    c_suspend: cover property (clock_enable_n_in ##1 clock_enable_n_in);
    c_standby: cover property (standby_out);
endmodule

bind plsram_port plsram_sva #(.DATA_W(DATA_W)) u_sva (.*);

// ---- plsram_host.sv ----
`timescale 1ns/100ps

module plsram_host #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 36
) (
    output logic clock_enable_n_in,
    output logic [ADDR_W-1:0] address_in,
    output logic advance_or_load_n_in,
    output logic read_not_write_in,
    output logic chip_enable_n_in,
    output logic expansion_select_high_in,
    output logic expansion_select_low_n_in,
    output logic lane0_write_mask_n_in,
    output logic lane1_write_mask_n_in,
    output logic lane2_write_mask_n_in,
    output logic lane3_write_mask_n_in,
    output logic burst_order_in,
    output logic output_enable_n_in,
    output logic snooze_request_in,
    output logic [DATA_W-1:0] lane_data_in
);
    logic [DATA_W-1:0] last_d = '0;
    // Pins for one edge, set after a falling edge and held to the next
    task automatic drive(input logic ld_n, rw, oe_n, ce_n, dph, input logic [2:0] ce,
                         input logic [ADDR_W-1:0] a, input logic [3:0] m_n, input logic [DATA_W-1:0] d);
        advance_or_load_n_in = ld_n;
        read_not_write_in = rw;
        output_enable_n_in = oe_n;
        clock_enable_n_in = ce_n;
        {chip_enable_n_in, expansion_select_high_in, expansion_select_low_n_in} = ce;
        address_in = a;
        // Lane masks ride with the address
        {lane3_write_mask_n_in, lane2_write_mask_n_in, lane1_write_mask_n_in, lane0_write_mask_n_in} = m_n;
        // Data only in the phase after a write, else a moving pattern
        lane_data_in = dph ? d : ~last_d;
        last_d = lane_data_in;
    endtask
    // Static pins, changed only between bursts
    task automatic statics(input logic ord, snz);
        burst_order_in = ord;
        snooze_request_in = snz;
    endtask
    // Idle at power-up: deselect load, no snooze
    initial begin
        statics(1'b0, 1'b0);
        drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'b110, '0, 4'hf, '0);
    end
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps

module tb;
    import plsram_pkg::*;
    localparam int AW = 4;
    localparam int DW = 36;
    logic mclk_in, rst_n_in, clock_enable_n_in, advance_or_load_n_in, read_not_write_in, chip_enable_n_in;
    logic expansion_select_high_in, expansion_select_low_n_in, burst_order_in, output_enable_n_in;
    logic lane0_write_mask_n_in, lane1_write_mask_n_in, lane2_write_mask_n_in, lane3_write_mask_n_in;
    logic snooze_request_in, lane_data_oe_out, standby_out;
    logic [AW-1:0] address_in, base, cur, wr_addr;
    logic [DW-1:0] lane_data_in, lane_data_out;
    logic [DW-1:0] mem [16];
    logic [1:0] cnt;
    logic wr_pend;
    plsram_mask_t wr_mask;
    plsram_op_t op;
    int seed = 34;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    plsram_port #(.ADDR_W(AW), .DATA_W(DW)) dut (.*);
    plsram_host #(.ADDR_W(AW), .DATA_W(DW)) host (.*);

    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    // Hang guard, far above the few hundred edges the run needs
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [DW-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Burst address from base and count
    function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] b, input logic [1:0] k, input logic ord);
        next_addr = {b[AW-1:2], ord ? b[1:0] ^ k : b[1:0] + k};
    endfunction
    // Lanes with a low mask take the new data
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, d, input plsram_mask_t m_n);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (!m_n[i]) merge[i*9 +: 9] = d[i*9 +: 9];
        end
    endfunction
    // One accepted edge; the model lands a pending write before this edge's read
    task automatic step(input logic ld_n, rw, oe_n, input logic [2:0] ce, input logic [AW-1:0] a,
                        input plsram_mask_t m_n);
        logic [DW-1:0] d;
        d = DW'({$random(seed), $random(seed)});
        @(negedge mclk_in);
        host.drive(ld_n, rw, oe_n, 1'b0, wr_pend, ce, a, m_n, d);
        if (!ld_n) begin
            base = a;
            cnt = 2'h0;
            op = (ce != 3'b010) ? OP_DESEL : (rw ? OP_READ : OP_WRITE);
        end else begin
            cnt = cnt + 2'h1;
        end
        cur = next_addr(base, cnt, burst_order_in);
        if (wr_pend) mem[wr_addr] = merge(mem[wr_addr], d, wr_mask);
        wr_pend = (op == OP_WRITE);
        wr_addr = cur;
        wr_mask = m_n;
        @(posedge mclk_in);
        #1;
        check(DW'(lane_data_oe_out), DW'(op == OP_READ && !oe_n));
        if (op == OP_READ) check(lane_data_out, mem[cur]);
    endtask
    // Suspended edges with random pins must leave everything alone
    task automatic hold(input int n);
        logic [DW-1:0] q;
        q = lane_data_out;
        repeat (n) begin
            @(negedge mclk_in);
            host.drive(1'($random(seed)), 1'($random(seed)), 1'b0, 1'b1, 1'b0, 3'b010, AW'($random(seed)),
                       4'($random(seed)), '0);
            @(posedge mclk_in);
            #1;
            check(lane_data_out, q);
        end
    endtask

    initial begin
        rst_n_in = 1'b0;
        wr_pend = 1'b0;
        op = OP_DESEL;
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_n_in = 1'b1;
        // Fill every word with linear write bursts of four
        for (int i = 0; i < 16; i++) step(i[1:0] != 0, 1'b0, 1'b0, 3'b010, AW'(i), 4'h0);
        $display("fill done");
        for (int ph = 0; ph < 2; ph++) begin
            step(1'b0, 1'b0, 1'b0, 3'b110, 4'h0, 4'hf);
            host.statics(ph[0], 1'b0);
            for (int k = 0; k < 150; k++) begin
                step(1'($random(seed)), 1'($random(seed)), ($random(seed) & 7) == 0,
                     ($random(seed) & 7) == 0 ? 3'($random(seed)) : 3'b010, AW'($random(seed)), 4'($random(seed)));
                if (($random(seed) & 15) == 0) hold(1 + ($random(seed) & 1));
            end
            $display("random phase %0d done", ph);
        end
        // Read right after a write to the same word, then an interleaved burst past its wrap
        step(1'b0, 1'b0, 1'b0, 3'b010, 4'h7, 4'ha);
        step(1'b0, 1'b1, 1'b0, 3'b010, 4'h7, 4'hf);
        for (int i = 0; i < 8; i++) step(i != 0, 1'b1, 1'b0, 3'b010, 4'hb, 4'h0);
        $display("corner cases done");
        // Snooze with write traffic on the pins; the array must survive
        host.statics(1'b1, 1'b1);
        repeat (3) @(posedge mclk_in);
        #1;
        check(DW'(standby_out), DW'(1));
        repeat (4) begin
            @(negedge mclk_in);
            host.drive(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'b010, AW'($random(seed)), 4'h0, DW'($random(seed)));
        end
        @(negedge mclk_in);
        host.drive(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'b110, 4'h0, 4'hf, '0);
        host.statics(1'b1, 1'b0);
        repeat (3) @(posedge mclk_in);
        for (int i = 0; i < 16; i++) step(1'b0, 1'b1, 1'b0, 3'b010, AW'(i), 4'hf);
        $display("snooze test done");
        test_done();
    end
endmodule
